// >>> progmem_pkg.sv
// Package of constants and types for the program memory read path
package progmem_pkg;
	// ==========================================
	// Widths and sizes
	localparam int WORD_W = 16;
	localparam int BYTE_W = 8;
	localparam int SMALL_WORDS = 2048;
	localparam int LARGE_WORDS = 4096;
	localparam int SMALL_PC_W = 11;
	localparam int LARGE_PC_W = 12;
	// ==========================================
	// Addresses and reset values
	localparam logic [11:0] RESET_VECTOR = 12'h000;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [15:0] WORD_ZERO = 16'h0000;
	// ==========================================
	// Request kinds issued by the core
	typedef enum logic [1:0] {REQ_FETCH, REQ_TAB_PAGE, REQ_TAB_LAST, REQ_PCL_WRITE} req_kind_t;
endpackage

// >>> progmem_if.sv
// Interface joining the core end and the program memory end
`timescale 1ns/1ps
interface progmem_if #(parameter int PC_W = 12);
	logic req;
	progmem_pkg::req_kind_t kind;
	logic [7:0] ptr_low;
	logic [7:0] ptr_high;
	logic [7:0] pcl_data;
	logic [4:0] dest;
	logic busy;
	logic fetch_valid;
	logic [15:0] instr;
	logic [PC_W-1:0] pc;
	logic tab_valid;
	logic [4:0] tab_dest;
	logic [7:0] tab_low;
	logic [7:0] high_latch;
	modport mem (input req, kind, ptr_low, ptr_high, pcl_data, dest,
		output busy, fetch_valid, instr, pc, tab_valid, tab_dest, tab_low, high_latch);
	modport core (output req, kind, ptr_low, ptr_high, pcl_data, dest,
		input busy, fetch_valid, instr, pc, tab_valid, tab_dest, tab_low, high_latch);
endinterface

// >>> progmem_core.sv
// Core end: issues fetches and table reads on user command
`timescale 1ns/1ps
module progmem_core
	import progmem_pkg::*;
(
	// Clock and reset
	input wire logic CLK_IN,
	input wire logic ARST_N_IN,
	// User command
	input wire logic CMD_VALID_IN,
	input wire req_kind_t CMD_KIND_IN,
	input wire logic [7:0] CMD_PTR_LOW_IN,
	input wire logic [7:0] CMD_PTR_HIGH_IN,
	input wire logic [7:0] CMD_PCL_IN,
	input wire logic [4:0] CMD_DEST_IN,
	output logic CMD_READY_OUT,
	// Results
	output logic RES_VALID_OUT,
	output logic [4:0] RES_DEST_OUT,
	output logic [7:0] RES_DATA_OUT,
	output logic [7:0] RES_HIGH_OUT,
	// Link
	progmem_if.core link
);
	// ==========================================
	// Request registers
	logic req_reg;
	// A command is taken only on an edge where ready was already shown
	wire logic take = CMD_VALID_IN && CMD_READY_OUT;
	// A table request in flight makes the memory end busy on the next edge
	wire logic tab_pending = req_reg && (link.kind == REQ_TAB_PAGE || link.kind == REQ_TAB_LAST);
	assign link.req = req_reg;
	always_ff @(posedge CLK_IN or negedge ARST_N_IN)
		if (!ARST_N_IN)
		begin
			req_reg <= 1'b0;
			link.kind <= REQ_FETCH;
			link.ptr_low <= BYTE_ZERO;
			link.ptr_high <= BYTE_ZERO;
			link.pcl_data <= BYTE_ZERO;
			link.dest <= 5'h0_0;
			CMD_READY_OUT <= 1'b0;
		end
		else
		begin
			req_reg <= take;
			CMD_READY_OUT <= !link.busy && !take && !tab_pending;
			if (take)
			begin
				// Interrupt-safe use of the shared latch is firmware's job
				link.kind <= CMD_KIND_IN;
				link.ptr_low <= CMD_PTR_LOW_IN;
				link.ptr_high <= CMD_PTR_HIGH_IN;
				link.pcl_data <= CMD_PCL_IN;
				link.dest <= CMD_DEST_IN;
			end
		end
	// ==========================================
	// Result capture
	always_ff @(posedge CLK_IN or negedge ARST_N_IN)
		if (!ARST_N_IN)
		begin
			RES_VALID_OUT <= 1'b0;
			RES_DEST_OUT <= 5'h0_0;
			RES_DATA_OUT <= BYTE_ZERO;
			RES_HIGH_OUT <= BYTE_ZERO;
		end
		else
		begin
			RES_VALID_OUT <= link.tab_valid;
			if (link.tab_valid)
			begin
				RES_DEST_OUT <= link.tab_dest;
				RES_DATA_OUT <= link.tab_low;
			end
			RES_HIGH_OUT <= link.high_latch;
		end
endmodule

// >>> progmem_mem.sv
// Program memory end: store, program counter, table read path
`timescale 1ns/1ps
// Summary of operation
// - 16-bit words, 2K or 4K deep
// - Fetches addressed by the program counter
// - Execution starts at word zero after reset
// - Table address from low pointer and high pointer or last page
// - Low table byte goes to destination register
// - High table byte loads the high latch
// - Unimplemented latch bits read zero
// - Page read: high pointer selects page
// - High latch cannot be written
// - Table reads take two cycles
// - Firmware guards latch against interrupt reads
// - Serial programming: one data line, external clock
// - Programming lines driven by nobody else
// - Debug: one data line, external clock
// - Emulation variant disables shared pin functions
// - Program counter 11 or 12 bits wide
module progmem_mem
	import progmem_pkg::*;
#(
	parameter int DEPTH = LARGE_WORDS,
	parameter int PC_W = LARGE_PC_W,
	parameter bit EMULATION = 1'b0
)
(
	// Clock and reset
	input wire logic CLK_IN,
	input wire logic ARST_N_IN,
	// Store loading from the programming side
	input wire logic LOAD_EN_IN,
	input wire logic [PC_W-1:0] LOAD_ADDR_IN,
	input wire logic [15:0] LOAD_DATA_IN,
	// Serial programming pins
	input wire logic PROG_SERIAL_CLOCK_IN,
	input wire logic PROG_SERIAL_DATA_IN,
	output logic PROG_SERIAL_DATA_OUT,
	output logic PROG_SERIAL_DATA_OE_OUT,
	// Debug pins
	input wire logic DEBUG_SERIAL_CLOCK_IN,
	input wire logic DEBUG_SERIAL_DATA_IN,
	output logic DEBUG_SERIAL_DATA_OUT,
	output logic DEBUG_SERIAL_DATA_OE_OUT,
	// Ordinary shared pin function
	input wire logic PIN_FUNC_DATA_IN,
	input wire logic PIN_FUNC_OE_IN,
	output logic PIN_FUNC_OUT,
	output logic PIN_FUNC_OE_OUT,
	// Serial activity seen
	output logic SERIAL_SEEN_OUT,
	// Link
	progmem_if.mem link
);
	// ==========================================
	// Elaboration check
	initial
	begin
		if (!((DEPTH == SMALL_WORDS && PC_W == SMALL_PC_W) ||
			(DEPTH == LARGE_WORDS && PC_W == LARGE_PC_W)))
			$error("Unsupported program memory size");
	end
	// ==========================================
	// Store
	logic [WORD_W-1:0] store [DEPTH];
	always_ff @(posedge CLK_IN)
		if (LOAD_EN_IN)
			store[LOAD_ADDR_IN] <= LOAD_DATA_IN;
	// ==========================================
	// Address forming
	function automatic logic [PC_W-1:0] tab_addr(input logic [7:0] hi, input logic [7:0] lo);
		logic [15:0] full;
		full = {hi, lo};
		return full[PC_W-1:0];
	endfunction
	localparam logic [7:0] LAST_PAGE = 8'(DEPTH / 256 - 1);
	wire logic is_tab = link.kind == REQ_TAB_PAGE || link.kind == REQ_TAB_LAST;
	wire logic [7:0] page_sel = (link.kind == REQ_TAB_LAST) ? LAST_PAGE : link.ptr_high;
	wire logic [PC_W-1:0] taddr = tab_addr(page_sel, link.ptr_low);
	// ==========================================
	// Sequencer
	typedef enum logic [1:0] {S_IDLE, S_TAB, S_DONE} state_t;
	state_t state_reg;
	logic [PC_W-1:0] pc_reg;
	logic [PC_W-1:0] taddr_reg;
	logic [4:0] dest_reg;
	logic [WORD_W-1:0] rd_word;
	assign rd_word = store[taddr_reg];
	assign link.pc = pc_reg;
	always_ff @(posedge CLK_IN or negedge ARST_N_IN)
		if (!ARST_N_IN)
		begin
			state_reg <= S_IDLE;
			pc_reg <= PC_W'(RESET_VECTOR);
			taddr_reg <= '0;
			dest_reg <= 5'h0_0;
			link.busy <= 1'b0;
			link.fetch_valid <= 1'b0;
			link.instr <= WORD_ZERO;
			link.tab_valid <= 1'b0;
			link.tab_dest <= 5'h0_0;
			link.tab_low <= BYTE_ZERO;
			link.high_latch <= BYTE_ZERO;
		end
		else
		begin
			link.fetch_valid <= 1'b0;
			link.tab_valid <= 1'b0;
			unique case (state_reg)
				S_IDLE:
					if (link.req && is_tab)
					begin
						taddr_reg <= taddr;
						dest_reg <= link.dest;
						link.busy <= 1'b1;
						state_reg <= S_TAB;
					end
					else if (link.req && link.kind == REQ_PCL_WRITE)
						pc_reg <= {pc_reg[PC_W-1:8], link.pcl_data};
					else if (link.req)
					begin
						link.instr <= store[pc_reg];
						link.fetch_valid <= 1'b1;
						pc_reg <= pc_reg + 1'b1;
					end
				S_TAB:
				begin
					link.tab_low <= rd_word[7:0];
					// Only a table read updates the latch
					link.high_latch <= 8'(rd_word[WORD_W-1:8]);
					link.tab_dest <= dest_reg;
					link.tab_valid <= 1'b1;
					state_reg <= S_DONE;
				end
				S_DONE:
				begin
					link.busy <= 1'b0;
					state_reg <= S_IDLE;
				end
				default:
					state_reg <= S_IDLE;
			endcase
		end
	// ==========================================
	// Pins: external tool clocks, shared line, emulation
	logic seen_reg;
	logic pclk_reg;
	always_ff @(posedge CLK_IN or negedge ARST_N_IN)
		if (!ARST_N_IN)
		begin
			pclk_reg <= 1'b0;
			seen_reg <= 1'b0;
			PROG_SERIAL_DATA_OUT <= 1'b0;
			PROG_SERIAL_DATA_OE_OUT <= 1'b0;
			DEBUG_SERIAL_DATA_OUT <= 1'b0;
			DEBUG_SERIAL_DATA_OE_OUT <= 1'b0;
			PIN_FUNC_OUT <= 1'b0;
			PIN_FUNC_OE_OUT <= 1'b0;
			SERIAL_SEEN_OUT <= 1'b0;
		end
		else
		begin
			// Clock is only sampled; the tool drives it
			pclk_reg <= PROG_SERIAL_CLOCK_IN | DEBUG_SERIAL_CLOCK_IN;
			if (pclk_reg)
				seen_reg <= 1'b1;
			SERIAL_SEEN_OUT <= seen_reg;
			// Device never drives serial data; protocol not implemented
			PROG_SERIAL_DATA_OUT <= PROG_SERIAL_DATA_IN & 1'b0;
			PROG_SERIAL_DATA_OE_OUT <= 1'b0;
			DEBUG_SERIAL_DATA_OUT <= DEBUG_SERIAL_DATA_IN & 1'b0;
			DEBUG_SERIAL_DATA_OE_OUT <= 1'b0;
			PIN_FUNC_OUT <= EMULATION ? 1'b0 : PIN_FUNC_DATA_IN;
			PIN_FUNC_OE_OUT <= EMULATION ? 1'b0 : PIN_FUNC_OE_IN;
		end
endmodule

// >>> progmem_sva.sv
// Checker of the link between the core end and the memory end
`timescale 1ns/1ps
module progmem_sva
	import progmem_pkg::*;
#(
	parameter int PC_W = 12
)
(
	// Clock and reset
	input wire logic CLK_IN,
	input wire logic ARST_N_IN,
	// Link signals
	input wire logic req,
	input wire req_kind_t kind,
	input wire logic [7:0] pcl_data,
	input wire logic busy,
	input wire logic fetch_valid,
	input wire logic [PC_W-1:0] pc,
	input wire logic tab_valid,
	input wire logic [7:0] high_latch
);
	wire logic tab_req;
	wire logic fetch_req;
	assign tab_req = req && (kind == REQ_TAB_PAGE || kind == REQ_TAB_LAST);
	assign fetch_req = req && kind == REQ_FETCH;
	default clocking @(posedge CLK_IN); endclocking
	default disable iff (!ARST_N_IN);
	// ==========================================
	// Assertions
	chk_table_busy: assert property (tab_req |=> busy[*2] ##1 !busy)
		else $error("busy span wrong");
	chk_table_due: assert property (tab_req |-> ##2 tab_valid)
		else $error("table answer late");
	chk_table_cause: assert property (tab_valid |-> busy && $past(tab_req, 2))
		else $error("table answer without request");
	chk_fetch_answer: assert property (fetch_req |=> fetch_valid && pc == $past(pc) + 1'b1)
		else $error("fetch answer wrong");
	chk_fetch_single: assert property (fetch_valid |=> !fetch_valid)
		else $error("fetch pulse too long");
	chk_pcl_load: assert property (req && kind == REQ_PCL_WRITE |=> pc[7:0] == $past(pcl_data))
		else $error("counter low byte not loaded");
	chk_latch_steady: assert property (!tab_valid |-> $stable(high_latch))
		else $error("high latch changed");
	chk_pc_start: assert property ($rose(ARST_N_IN) |-> pc == '0)
		else $error("counter not zero after reset");
	cover property (fetch_req);
	cover property (req && kind == REQ_TAB_PAGE);
	cover property (req && kind == REQ_TAB_LAST);
	cover property (req && kind == REQ_PCL_WRITE);
endmodule

// >>> test_program_memory_table_read.sv
// Testbench joining the core end and the memory end
`timescale 1ns/1ps
module test_program_memory_table_read
	import progmem_pkg::*;
;
	logic clk = 0, rst_n = 0, vld = 0, ld = 0, ser = 0, pin = 0;
	req_kind_t knd = REQ_FETCH;
	logic [7:0] lo = 8'h00, hi = 8'h00;
	logic [11:0] la = 12'h000;
	logic [15:0] ld_data = 16'h0000;
	logic rdy, rv, pout, poe, seen, poe1, poe2, pdo, ddo;
	logic [4:0] rdest;
	logic [7:0] rdata, rhigh;
	logic [11:0] addrs [5] = '{12'h000, 12'h001, 12'h306, 12'hF05, 12'hF06};
	int mismatches = 0, total_checks = 0;
	progmem_if #(.PC_W(12)) link ();
	progmem_core u_progmem_core (.CLK_IN(clk), .ARST_N_IN(rst_n), .CMD_VALID_IN(vld),
		.CMD_KIND_IN(knd), .CMD_PTR_LOW_IN(lo), .CMD_PTR_HIGH_IN(hi), .CMD_PCL_IN(lo),
		.CMD_DEST_IN(lo[4:0]), .CMD_READY_OUT(rdy), .RES_VALID_OUT(rv), .RES_DEST_OUT(rdest),
		.RES_DATA_OUT(rdata), .RES_HIGH_OUT(rhigh), .link(link));
	progmem_mem #(.DEPTH(4096), .PC_W(12), .EMULATION(1'b0)) u_progmem_mem (.CLK_IN(clk),
		.ARST_N_IN(rst_n), .LOAD_EN_IN(ld), .LOAD_ADDR_IN(la), .LOAD_DATA_IN(ld_data),
		.PROG_SERIAL_CLOCK_IN(ser), .PROG_SERIAL_DATA_IN(ser), .PROG_SERIAL_DATA_OUT(pdo),
		.PROG_SERIAL_DATA_OE_OUT(poe1), .DEBUG_SERIAL_CLOCK_IN(ser),
		.DEBUG_SERIAL_DATA_IN(ser), .DEBUG_SERIAL_DATA_OUT(ddo), .DEBUG_SERIAL_DATA_OE_OUT(poe2),
		.PIN_FUNC_DATA_IN(pin), .PIN_FUNC_OE_IN(pin), .PIN_FUNC_OUT(pout),
		.PIN_FUNC_OE_OUT(poe), .SERIAL_SEEN_OUT(seen), .link(link));
	progmem_sva #(.PC_W(12)) u_progmem_sva (.CLK_IN(clk), .ARST_N_IN(rst_n), .req(link.req),
		.kind(link.kind), .pcl_data(link.pcl_data), .busy(link.busy),
		.fetch_valid(link.fetch_valid), .pc(link.pc), .tab_valid(link.tab_valid),
		.high_latch(link.high_latch));
	always #50 clk = ~clk;
	// ==========================================
	// Tasks
	function automatic logic [15:0] pat(input logic [11:0] a);
		pat = {a[7:0], 4'h0, a[11:8]} ^ 16'hC35A;
	endfunction
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic load(input logic [11:0] a);
		@(posedge clk);
		ld <= 1'b1;
		la <= a;
		ld_data <= pat(a);
		@(posedge clk);
		ld <= 1'b0;
	endtask
	task automatic run(input req_kind_t k, input logic [7:0] h, input logic [7:0] l);
		int n;
		n = 0;
		@(posedge clk);
		knd <= k;
		hi <= h;
		lo <= l;
		vld <= 1'b1;
		@(negedge clk);
		while (rdy !== 1'b1 && n < 50)
		begin
			@(negedge clk);
			n++;
		end
		@(posedge clk);
		vld <= 1'b0;
		n = 0;
		do
		begin
			@(negedge clk);
			n++;
		end
		while (n < 20 && !(k == REQ_FETCH ? link.fetch_valid === 1'b1 :
			k == REQ_PCL_WRITE ? n > 2 : rv === 1'b1));
		if (n >= 20)
			check(16'h0000, 16'h0001);
	endtask
	task automatic print_verdict();
		if (mismatches == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// ==========================================
	// Tests
	initial
	begin
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		foreach (addrs[i])
			load(addrs[i]);
		check(16'(link.pc), 16'h0000);
		run(REQ_FETCH, 8'h00, 8'h00);
		check(link.instr, pat(12'h000));
		run(REQ_FETCH, 8'h00, 8'h00);
		check(link.instr, pat(12'h001));
		check(16'(link.pc), 16'h0002);
		run(REQ_PCL_WRITE, 8'h00, 8'h06);
		check(16'(link.pc), 16'h0006);
		run(REQ_TAB_PAGE, 8'h03, 8'h06);
		check({rhigh, rdata}, pat(12'h306));
		check(16'(rdest), 16'h0006);
		run(REQ_TAB_LAST, 8'h03, 8'h05);
		check({rhigh, rdata}, pat(12'hF05));
		run(REQ_FETCH, 8'h00, 8'h00);
		check(16'(link.high_latch), pat(12'hF05) >> 8);
		check(16'({seen, pout, poe, pdo, ddo}), 16'h0000);
		@(posedge clk);
		ser <= 1'b1;
		pin <= 1'b1;
		repeat (5) @(negedge clk);
		check(16'({seen, pout, poe, poe1, poe2, pdo, ddo}), 16'h0070);
		print_verdict();
	end
	initial
	begin
		#200000;
		mismatches++;
		print_verdict();
	end
endmodule
